// File: hw/exec_slice.sv
// Core execution slice: fetch, decode and execute of one instruction group
//
// The register addresses and the plain strobed port were chosen for this implementation.
module exec_slice
   import exec_slice_pkg::*;
#(
   parameter int DEPTH = STACK_DEPTH,
   parameter int PRESCALE_BITS = PRESCALE_W
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Program memory
   output logic [PC_W-1:0] instr_addr,
   input wire logic [INSTR_W-1:0] instr_data,
   // Register bus
   input wire logic [BUS_ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [DATA_W-1:0] rdata,
   // Core state
   output logic timeout_flag,
   output logic powerdown_flag,
   output logic zero_flag
);

   localparam int PTR_W = $clog2(DEPTH);

   // ------------------------------------------------------------
   // Parameter check
   // ------------------------------------------------------------
   if (PRESCALE_BITS < 1 || PRESCALE_BITS > 16)
   begin : g_bad_prescale
      $error("exec_slice prescaler width must be 1 to 16");
   end

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   function automatic op_t decode(input logic [INSTR_W-1:0] word);
      op_t op;
      op = op_nop;
      if ((word & FULL_MASK) == CLEAR_WATCHDOG_CODE)
      begin
         op = op_clear_watchdog;
      end
      else if ((word & CALL_MASK) == CALL_CODE)
      begin
         op = op_call;
      end
      else if ((word & BYTE_OP_MASK) == COMPLEMENT_CODE)
      begin
         op = op_complement;
      end
      else if ((word & BYTE_OP_MASK) == DECREMENT_CODE)
      begin
         op = op_decrement;
      end
      else if ((word & BYTE_OP_MASK) == DECREMENT_SKIP_CODE)
      begin
         op = op_decrement_skip;
      end
      else if ((word & CLEAR_MASK) == CLEAR_REGISTER_CODE)
      begin
         op = op_clear_register;
      end
      else if ((word & CLEAR_MASK) == CLEAR_ACCUMULATOR_CODE)
      begin
         op = op_clear_accumulator;
      end
      return op;
   endfunction

   function automatic logic is_zero(input logic [DATA_W-1:0] value);
      return value == BYTE_ZERO;
   endfunction

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   exec_state_t state;
   exec_state_t next_state;
   logic [PC_W-1:0] pc;
   logic [PC_W-1:0] next_pc;
   logic [DATA_W-1:0] accumulator;
   logic [LATCH_W-1:0] pc_high_latch;
   logic run;
   logic [DATA_W-1:0] watchdog_counter;
   logic [PRESCALE_BITS-1:0] prescaler;
   logic [DATA_W-1:0] file_mem [2**FILE_ADDR_W];
   logic [PC_W-1:0] stack_top;
   logic [PTR_W-1:0] stack_pointer;

   // ------------------------------------------------------------
   // Operand and result paths
   // ------------------------------------------------------------
   wire op_t op = (state == st_exec) ? decode(instr_data) : op_nop;
   wire logic [FILE_ADDR_W-1:0] file_addr = instr_data[FILE_ADDR_W-1:0];
   wire logic to_register = instr_data[DEST_BIT];
   wire logic [TARGET_W-1:0] call_target = instr_data[TARGET_W-1:0];
   wire logic [DATA_W-1:0] file_value = file_mem[file_addr];
   wire logic [DATA_W-1:0] complement_value = ~file_value;
   wire logic [DATA_W-1:0] decrement_value = file_value - BYTE_ONE;
   wire logic is_decrement = (op == op_decrement) || (op == op_decrement_skip);
   wire logic is_byte_op = (op == op_complement) || is_decrement;

   wire logic [DATA_W-1:0] result =
      (op == op_complement) ? complement_value :  // see [RULE_07]
      is_decrement ? decrement_value :  // see [RULE_09] see [RULE_11]
      BYTE_ZERO;  // see [RULE_08] see [RULE_10]

   wire logic write_file = (is_byte_op && to_register) || (op == op_clear_register);
   wire logic write_acc = (is_byte_op && !to_register) || (op == op_clear_accumulator);
   // Decrement-skip leaves every flag alone
   wire logic zero_update = (op == op_complement) || (op == op_decrement)
      || (op == op_clear_register) || (op == op_clear_accumulator);  // see [RULE_11]
   wire logic skip = (op == op_decrement_skip) && is_zero(decrement_value);  // see [RULE_12]
   wire logic do_call = (op == op_call);
   wire logic clear_watchdog = (op == op_clear_watchdog);

   // ------------------------------------------------------------
   // Sequencing
   // ------------------------------------------------------------
   always_comb
   begin
      next_state = state;
      next_pc = pc;
      case (state)
         st_fill:
         begin
            if (run)
            begin
               next_state = st_exec;
               next_pc = pc + PC_W'(1);
            end
         end
         st_exec:
         begin
            if (do_call)
            begin
               // Target in low bits, page from latch; fetched word is dropped
               next_pc = {pc_high_latch[LATCH_HI_BIT:LATCH_LO_BIT], call_target};  // see [RULE_04] see [RULE_05]
               next_state = st_flush;  // see [RULE_06]
            end
            else if (skip)
            begin
               next_pc = pc + PC_W'(1);
               next_state = st_flush;  // see [RULE_12]
            end
            else if (!run)
            begin
               next_pc = pc - PC_W'(1);
               next_state = st_fill;
            end
            else
            begin
               next_pc = pc + PC_W'(1);  // see [RULE_13]
            end
         end
         st_flush:
         begin
            // Word arriving now is discarded and acts as a no-op
            next_pc = pc + PC_W'(1);  // see [RULE_06] see [RULE_12]
            next_state = st_exec;
         end
         default:
         begin
            next_state = st_fill;
            next_pc = pc;
         end
      endcase
   end

   assign instr_addr = pc;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state <= st_fill;
         pc <= PC_RESET;
      end
      else
      begin
         state <= next_state;
         pc <= next_pc;
      end
   end

   // ------------------------------------------------------------
   // Return stack
   // ------------------------------------------------------------
   // pc already holds the address of the following instruction
   return_stack #(
      .DEPTH(DEPTH),
      .WIDTH(PC_W)
   ) u_stack (
      .clk(clk),
      .rst(rst),
      .push(do_call),  // see [RULE_03]
      .push_value(pc),  // see [RULE_03]
      .stack_top(stack_top),
      .stack_pointer(stack_pointer)
   );

   // ------------------------------------------------------------
   // Accumulator and flags
   // ------------------------------------------------------------
   wire logic watchdog_expire = (&prescaler) && (&watchdog_counter);

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         accumulator <= BYTE_ZERO;
         zero_flag <= ZERO_RESET;
      end
      else
      begin
         if (write_acc)
         begin
            accumulator <= result;  // see [RULE_07] see [RULE_09] see [RULE_10]
         end
         if (zero_update)
         begin
            zero_flag <= is_zero(result);  // see [RULE_07] see [RULE_08] see [RULE_10]
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         timeout_flag <= TIMEOUT_RESET;
         powerdown_flag <= POWERDOWN_RESET;
      end
      else if (clear_watchdog)
      begin
         // Instruction wins over a same-cycle expiry
         timeout_flag <= 1'b1;  // see [RULE_02]
         powerdown_flag <= 1'b1;  // see [RULE_02]
      end
      else if (watchdog_expire)
      begin
         timeout_flag <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Watchdog counter and prescaler
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (rst || clear_watchdog)
      begin
         prescaler <= '0;  // see [RULE_01]
         watchdog_counter <= BYTE_ZERO;  // see [RULE_01]
      end
      else
      begin
         prescaler <= prescaler + PRESCALE_BITS'(1);
         if (&prescaler)
         begin
            watchdog_counter <= watchdog_counter + BYTE_ONE;
         end
      end
   end

   // ------------------------------------------------------------
   // File registers; the core write wins over a bus write
   // ------------------------------------------------------------
   wire logic bus_file = (addr <= FILE_LAST_OFFSET);
   wire logic [FILE_ADDR_W-1:0] bus_file_addr = addr[FILE_ADDR_W-1:0];

   always_ff @(posedge clk)
   begin
      if (write_file)
      begin
         file_mem[file_addr] <= result;  // see [RULE_07] see [RULE_08] see [RULE_09] see [RULE_11]
      end
      if (wr && bus_file && !(write_file && bus_file_addr == file_addr))
      begin
         file_mem[bus_file_addr] <= wdata;
      end
   end

   // ------------------------------------------------------------
   // Control registers
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         run <= RUN_RESET;
         pc_high_latch <= '0;
      end
      else if (wr)
      begin
         if (addr == CONTROL_OFFSET)
         begin
            run <= wdata[0];
         end
         if (addr == PC_HIGH_LATCH_OFFSET)
         begin
            pc_high_latch <= wdata[LATCH_W-1:0];
         end
      end
   end

   // ------------------------------------------------------------
   // Read data, valid the cycle after the strobe
   // ------------------------------------------------------------
   logic [DATA_W-1:0] read_mux;

   always_comb
   begin
      read_mux = BYTE_ZERO;
      if (bus_file)
      begin
         read_mux = file_mem[bus_file_addr];
      end
      else
      begin
         case (addr)
            CONTROL_OFFSET: read_mux = {7'h00, run};
            ACCUMULATOR_OFFSET: read_mux = accumulator;
            STATUS_OFFSET:
            begin
               read_mux[TIMEOUT_BIT] = timeout_flag;
               read_mux[POWERDOWN_BIT] = powerdown_flag;
               read_mux[ZERO_BIT] = zero_flag;
            end
            PC_HIGH_LATCH_OFFSET: read_mux = {3'h0, pc_high_latch};
            PC_LOW_OFFSET: read_mux = pc[7:0];
            PC_HIGH_OFFSET: read_mux = {3'h0, pc[PC_W-1:8]};
            WATCHDOG_OFFSET: read_mux = watchdog_counter;
            STACK_TOP_LOW_OFFSET: read_mux = stack_top[7:0];
            STACK_TOP_HIGH_OFFSET: read_mux = {3'h0, stack_top[PC_W-1:8]};
            STACK_POINTER_OFFSET: read_mux = DATA_W'(stack_pointer);
            default: read_mux = BYTE_ZERO;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         rdata <= BYTE_ZERO;
      end
      else if (rd)
      begin
         rdata <= read_mux;
      end
      else
      begin
         rdata <= BYTE_ZERO;
      end
   end

endmodule

// File: hw/return_stack.sv
// Circular hardware return stack holding pushed return addresses
module return_stack
   import exec_slice_pkg::*;
#(
   parameter int DEPTH = STACK_DEPTH,
   parameter int WIDTH = PC_W
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Push side
   input wire logic push,
   input wire logic [WIDTH-1:0] push_value,
   // Observation
   output logic [WIDTH-1:0] stack_top,
   output logic [$clog2(DEPTH)-1:0] stack_pointer
);

   localparam int PTR_W = $clog2(DEPTH);

   logic [WIDTH-1:0] slot [DEPTH];
   logic [PTR_W-1:0] next_pointer;

   // ------------------------------------------------------------
   // Parameter check
   // ------------------------------------------------------------
   if (DEPTH < 2 || (1 << PTR_W) != DEPTH)
   begin : g_bad_depth
      $error("return_stack depth must be a power of two, at least 2");
   end

   // ------------------------------------------------------------
   // Pointer wraps round when full, overwriting the oldest entry
   // ------------------------------------------------------------
   assign next_pointer = stack_pointer + PTR_W'(1);
   assign stack_top = slot[stack_pointer];

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         stack_pointer <= '0;
      end
      else if (push)
      begin
         stack_pointer <= next_pointer;
      end
   end

   always_ff @(posedge clk)
   begin
      if (push)
      begin
         slot[next_pointer] <= push_value;
      end
   end

endmodule

// File: inc/exec_slice_pkg.sv
// Constants and types shared by the instruction execution slice
// Notes on behaviour
// [RULE_01] Clear-watchdog zeroes watchdog counter and prescaler
// [RULE_02] Clear-watchdog sets timeout and powerdown flags only
// [RULE_03] Call pushes program counter plus one first
// [RULE_04] Call loads 11-bit target into pc bits 10:0
// [RULE_05] Call takes pc bits 12:11 from latch 4:3
// [RULE_06] Call lasts two cycles, flags untouched
// [RULE_07] Complement register to accumulator or register, zero updated
// [RULE_08] Clear register writes zero, sets zero flag
// [RULE_09] Decrement register to chosen destination, zero updated
// [RULE_10] Clear accumulator writes zero, sets zero flag
// [RULE_11] Decrement-skip writes result, leaves all flags
// [RULE_12] Zero result discards next instruction as no-op
// [RULE_13] Other instructions take one cycle, pc plus one
package exec_slice_pkg;

   // ------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------
   localparam int PC_W = 13;
   localparam int INSTR_W = 14;
   localparam int DATA_W = 8;
   localparam int FILE_ADDR_W = 7;
   localparam int TARGET_W = 11;
   localparam int LATCH_W = 5;
   localparam int BUS_ADDR_W = 8;
   localparam int STACK_DEPTH = 8;
   localparam int PRESCALE_W = 7;

   // ------------------------------------------------------------
   // Instruction encodings (value under mask)
   // ------------------------------------------------------------
   localparam logic [13:0] CLEAR_WATCHDOG_CODE = 14'h0064;
   localparam logic [13:0] FULL_MASK = 14'h3fff;
   localparam logic [13:0] CALL_CODE = 14'h2000;
   localparam logic [13:0] CALL_MASK = 14'h3800;
   localparam logic [13:0] COMPLEMENT_CODE = 14'h0900;
   localparam logic [13:0] DECREMENT_CODE = 14'h0300;
   localparam logic [13:0] DECREMENT_SKIP_CODE = 14'h0b00;
   localparam logic [13:0] BYTE_OP_MASK = 14'h3f00;
   localparam logic [13:0] CLEAR_REGISTER_CODE = 14'h0180;
   localparam logic [13:0] CLEAR_ACCUMULATOR_CODE = 14'h0100;
   localparam logic [13:0] CLEAR_MASK = 14'h3f80;
   localparam int DEST_BIT = 7;

   // ------------------------------------------------------------
   // Status layout and reset values
   // ------------------------------------------------------------
   localparam int TIMEOUT_BIT = 4;
   localparam int POWERDOWN_BIT = 3;
   localparam int ZERO_BIT = 2;
   localparam int LATCH_HI_BIT = 4;
   localparam int LATCH_LO_BIT = 3;
   localparam logic TIMEOUT_RESET = 1'b1;
   localparam logic POWERDOWN_RESET = 1'b1;
   localparam logic ZERO_RESET = 1'b0;
   localparam logic RUN_RESET = 1'b0;
   localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
   localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
   localparam logic [DATA_W-1:0] BYTE_ONE = 8'h01;

   // ------------------------------------------------------------
   // Register bus map
   // ------------------------------------------------------------
   localparam logic [7:0] FILE_LAST_OFFSET = 8'h7f;
   localparam logic [7:0] CONTROL_OFFSET = 8'h80;
   localparam logic [7:0] ACCUMULATOR_OFFSET = 8'h81;
   localparam logic [7:0] STATUS_OFFSET = 8'h82;
   localparam logic [7:0] PC_HIGH_LATCH_OFFSET = 8'h83;
   localparam logic [7:0] PC_LOW_OFFSET = 8'h84;
   localparam logic [7:0] PC_HIGH_OFFSET = 8'h85;
   localparam logic [7:0] WATCHDOG_OFFSET = 8'h86;
   localparam logic [7:0] STACK_TOP_LOW_OFFSET = 8'h87;
   localparam logic [7:0] STACK_TOP_HIGH_OFFSET = 8'h88;
   localparam logic [7:0] STACK_POINTER_OFFSET = 8'h89;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      op_nop,
      op_clear_watchdog,
      op_call,
      op_complement,
      op_clear_register,
      op_decrement,
      op_clear_accumulator,
      op_decrement_skip
   } op_t;

   typedef enum logic [1:0] {
      st_fill,
      st_exec,
      st_flush
   } exec_state_t;

endpackage

// File: verif/exec_slice_asserts.sv
// Port assertions for the execution slice
module exec_slice_asserts
   import exec_slice_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Program memory
   input wire logic [PC_W-1:0] instr_addr,
   input wire logic [INSTR_W-1:0] instr_data,
   // Register bus
   input wire logic [BUS_ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [DATA_W-1:0] rdata,
   // Flags
   input wire logic timeout_flag,
   input wire logic powerdown_flag,
   input wire logic zero_flag
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);

   // ----------------------------------------
   // Execute-cycle tracking from the bus
   // ----------------------------------------
   logic run_q;
   logic fill_q;
   logic hold_q;
   logic [1:0] page_q;
   wire ctl_wr = wr && (addr == CONTROL_OFFSET);
   wire is_call = (instr_data & CALL_MASK) == CALL_CODE;
   wire is_skip = (instr_data & BYTE_OP_MASK) == DECREMENT_SKIP_CODE;
   wire exec_now = run_q && !fill_q && !hold_q;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         run_q <= 1'b0;
         fill_q <= 1'b0;
         hold_q <= 1'b0;
         page_q <= 2'h0;
      end
      else
      begin
         if (ctl_wr)
            run_q <= wdata[0];
         if (wr && addr == PC_HIGH_LATCH_OFFSET)
            page_q <= wdata[4:3];
         fill_q <= ctl_wr && wdata[0] && !run_q;
         hold_q <= exec_now && (is_call || is_skip);
      end
   end

   // ----------------------------------------
   // Properties
   // ----------------------------------------
   sequence s_call_go;
      exec_now && is_call;
   endsequence
   sequence s_step;
      instr_addr == $past(instr_addr) + 13'h1;
   endsequence
   property p_call_target;
      s_call_go |=> instr_addr[10:0] == $past(instr_data[10:0]);
   endproperty
   property p_call_page;
      s_call_go |=> instr_addr[12:11] == $past(page_q);
   endproperty
   property p_call_two;
      s_call_go |=> ##1 s_step;
   endproperty
   property p_call_flags;
      s_call_go |=> ($stable(zero_flag) && $stable(powerdown_flag))[*2];
   endproperty
   property p_step;
      exec_now && !is_call && !is_skip && !ctl_wr |=> s_step;
   endproperty
   property p_wdt_flags;
      exec_now && instr_data == CLEAR_WATCHDOG_CODE |=>
         timeout_flag && powerdown_flag && $stable(zero_flag);
   endproperty
   property p_clear_register_instr_zero;
      exec_now && (instr_data & CLEAR_MASK) == CLEAR_REGISTER_CODE |=> zero_flag;
   endproperty
   property p_clear_accumulator_instr_zero;
      exec_now && (instr_data & CLEAR_MASK) == CLEAR_ACCUMULATOR_CODE |=> zero_flag;
   endproperty
   property p_skip_flags;
      exec_now && is_skip |=> $stable(zero_flag) && $stable(powerdown_flag);
   endproperty
   property p_rdata_idle;
      !rd |=> rdata == 8'h00;
   endproperty

   a_call_target: assert property (p_call_target)
      else $error("call target low bits wrong");
   a_call_page: assert property (p_call_page)
      else $error("call page bits wrong");
   a_call_two: assert property (p_call_two)
      else $error("call not two cycles");
   a_call_flags: assert property (p_call_flags)
      else $error("call changed a flag");
   a_step: assert property (p_step)
      else $error("single cycle step wrong");
   a_wdt_flags: assert property (p_wdt_flags)
      else $error("watchdog clear flags wrong");
   a_clear_register_instr_zero: assert property (p_clear_register_instr_zero)
      else $error("clear register zero flag low");
   a_clear_accumulator_instr_zero: assert property (p_clear_accumulator_instr_zero)
      else $error("clear accumulator zero flag low");
   a_skip_flags: assert property (p_skip_flags)
      else $error("decrement skip changed a flag");
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data not zero when idle");
endmodule

bind exec_slice exec_slice_asserts chk (.clk(clk), .rst(rst), .instr_addr(instr_addr),
   .instr_data(instr_data), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
   .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag), .zero_flag(zero_flag));

// File: verif/instr_exec_clear_call_decrement_bench.sv
// Self-checking testbench for the execution slice
module instr_exec_clear_call_decrement_bench
   import exec_slice_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] rdata;
   logic [PC_W-1:0] instr_addr;
   logic [INSTR_W-1:0] instr_data;
   logic timeout_flag;
   logic powerdown_flag;
   logic zero_flag;
   int err_count = 0;
   int checked = 0;
   int cycles = 0;

   always #50 clk = ~clk;

   exec_slice #(.PRESCALE_BITS(1)) uut (.clk(clk), .rst(rst), .instr_addr(instr_addr),
      .instr_data(instr_data), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag), .zero_flag(zero_flag));
   prog_mem_model pm (.clk(clk), .instr_addr(instr_addr), .instr_data(instr_data));

   // ----------------------------------------
   // Bus tasks and checks
   // ----------------------------------------
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         err_count++;
         report_and_stop();
      end
   end

   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
      checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
      logic [7:0] d;
      bus_rd(a, d);
      check(d, exp, what);
   endtask

   task automatic do_reset(input int n);
      @(posedge clk);
      rst <= 1'b1;
      repeat (n) @(posedge clk);
      rst <= 1'b0;
   endtask

   // ----------------------------------------
   // Expectations
   // ----------------------------------------
   function automatic logic [13:0] encode(input int k, input logic d, input logic [6:0] f);
      case (k)
         0: return COMPLEMENT_CODE | {6'h00, d, f};
         1: return DECREMENT_CODE | {6'h00, d, f};
         2: return DECREMENT_SKIP_CODE | {6'h00, d, f};
         3: return CLEAR_REGISTER_CODE | {7'h00, f};
         4: return CLEAR_ACCUMULATOR_CODE | {7'h00, f};
         default: return CLEAR_WATCHDOG_CODE;
      endcase
   endfunction

   function automatic void predict(input int k, input logic [7:0] v, input logic d,
      output logic [7:0] w, output logic [7:0] f, output logic z, output logic skip);
      logic [7:0] r;
      r = (k == 0) ? ~v : v - 8'h01;
      w = 8'h00;
      f = (k == 3) ? 8'h00 : v;
      z = (k == 3 || k == 4);
      skip = (k == 2) && (r == 8'h00);
      if (k <= 2 && d)
         f = r;
      if (k <= 2 && !d)
         w = r;
      if (k <= 1)
         z = (r == 8'h00);
   endfunction

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      logic [7:0] v, w_exp, f_exp, page, d8;
      logic [6:0] fa;
      logic [10:0] k;
      logic d, z_exp, skip;
      int kind;
      kind = $urandom(32'hb665);
      do_reset(6);
      for (int i = 0; i < 24; i++)
      begin
         kind = i % 6;
         fa = 7'($urandom_range(0, 126));
         v = (i % 4 == 0) ? 8'h01 : (i % 4 == 1) ? 8'h00 : 8'($urandom);
         d = 1'($urandom);
         k = 11'($urandom_range(16, 2000));
         page = 8'($urandom);
         pm.mem[0] = encode(kind, d, fa);
         pm.mem[1] = CALL_CODE | {3'h0, k};
         predict(kind, v, d, w_exp, f_exp, z_exp, skip);
         do_reset(1);
         bus_wr({1'b0, fa}, v);
         bus_wr(PC_HIGH_LATCH_OFFSET, page);
         bus_wr(ACCUMULATOR_OFFSET, v);
         bus_wr(STATUS_OFFSET, 8'hff);
         bus_wr(CONTROL_OFFSET, 8'h01);
         repeat (12) @(posedge clk);
         bus_wr(CONTROL_OFFSET, 8'h00);
         rd_chk(ACCUMULATOR_OFFSET, w_exp, "accumulator");
         rd_chk({1'b0, fa}, f_exp, "file register");
         bus_rd(STATUS_OFFSET, d8);
         check(d8 & 8'h1c, {3'h0, 2'b11, z_exp, 2'h0}, "status");
         check({7'h00, zero_flag}, {7'h00, z_exp}, "zero flag");
         rd_chk(STACK_POINTER_OFFSET, skip ? 8'h00 : 8'h01, "stack depth");
         if (!skip)
            rd_chk(STACK_TOP_LOW_OFFSET, 8'h02, "return address");
         bus_rd(PC_HIGH_OFFSET, d8);
         check(d8 & 8'h18, skip ? 8'h00 : page & 8'h18, "pc page");
         rd_chk(8'($urandom_range(8'h8a, 8'hff)), 8'h00, "unmapped read");
         $display("test %0d done", i);
      end
      pm.mem[0] = 14'h0000;
      pm.mem[1] = 14'h0000;
      pm.mem[700] = CLEAR_WATCHDOG_CODE;
      do_reset(1);
      bus_wr(CONTROL_OFFSET, 8'h01);
      repeat (600) @(posedge clk);
      check({7'h00, timeout_flag}, 8'h00, "timeout before clear");
      for (int n = 0; n < 200 && instr_addr !== 13'd702; n++)
         @(posedge clk);
      bus_rd(WATCHDOG_OFFSET, d8);
      check({7'h00, d8 <= 8'h03}, 8'h01, "watchdog cleared");
      check({6'h00, timeout_flag, powerdown_flag}, 8'h03, "flags set");
      $display("watchdog test done");
      report_and_stop();
   end
endmodule

// File: verif/prog_mem_model.sv
// Program memory model with one cycle read latency
module prog_mem_model
   import exec_slice_pkg::*;
(
   // Clock
   input wire logic clk,
   // Fetch port
   input wire logic [PC_W-1:0] instr_addr,
   output logic [INSTR_W-1:0] instr_data
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [INSTR_W-1:0] mem [0:(1<<PC_W)-1];

   initial
   begin
      instr_data = 14'h0000;
      foreach (mem[i])
         mem[i] = 14'h0000;
   end

   always @(posedge clk)
   begin
      instr_data <= mem[instr_addr];
   end
endmodule
